// [rtl/fpe_pkg.sv]
// Shared constants for the flash program/erase/protect control and its
// sequencer. Assumes a 100 MHz system clock on both ends.
package fpe_pkg;

  localparam int CLK_NS = 10;

  // Control byte field positions.
  localparam int CTL_PSEL  = 0;
  localparam int CTL_ERASE = 1;
  localparam int CTL_MASS  = 2;
  localparam int CTL_HVE   = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Array window, protect byte, page and row geometry.
  localparam logic [15:0] ARRAY_BASE = 16'hc000;
  localparam logic [15:0] PROT_ADDR  = 16'hff7e;
  localparam logic [15:0] SEC_PAGE   = 16'hffc0;
  localparam logic [7:0]  PROT_OPEN  = 8'hff;
  localparam logic [7:0]  PROT_VECT  = 8'hfe;
  localparam logic [7:0]  ERASED     = 8'hff;
  localparam int PAGE_BYTES = 64;
  localparam int ROW_BYTES  = 32;

  // Minimum times in ns, then minimum cycle counts rounded up.
  localparam int T_HVSU_NS  = 10000;
  localparam int T_HVHD_NS  = 5000;
  localparam int T_MEHD_NS  = 100000;
  localparam int T_PSU_NS   = 5000;
  localparam int T_BYTE_NS  = 30000;
  localparam int T_RREC_NS  = 1000;
  localparam int T_ERASE_NS = 4000000;
  localparam int T_HVSU_CYC  = (T_HVSU_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_HVHD_CYC  = (T_HVHD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_MEHD_CYC  = (T_MEHD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_PSU_CYC   = (T_PSU_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_BYTE_CYC  = (T_BYTE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RREC_CYC  = (T_RREC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    OP_PROGRAM    = 2'h0,
    OP_PAGE_ERASE = 2'h1,
    OP_MASS_ERASE = 2'h2
  } fpe_op_t;

endpackage

// [rtl/fpe_if.sv]
// Byte bus between the CPU-side sequencer and the flash control block.
// Assumes both ends share one clock; requests are one-cycle strobes.
`timescale 1ns/1ps
interface fpe_if;
  logic        bus_wr;
  logic        bus_rd;
  logic        bus_ctl;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;

  modport dev (
    input  bus_wr, bus_rd, bus_ctl, bus_addr, bus_wdata,
    output bus_rdata
  );
  modport cpu (
    output bus_wr, bus_rd, bus_ctl, bus_addr, bus_wdata,
    input  bus_rdata
  );
endinterface

// [rtl/fpe_flash_ctrl.sv]
// Flash control block: control byte, protect byte, array and the sequence
// interlocks. Assumes a CPU on fpe_if.dev driving one-cycle strobes.
//
// What this block does
// - High voltage only after legal select sequence.
// - Mass bit picks whole-array or page erase.
// - Program and erase selects never both one.
// - Page erase order is set by software.
// - Page erase waits are software's duty.
// - Security page survives page erase.
// - Software picks long or short erase.
// - Mass erase order is set by software.
// - Mass erase refused unless protect is open.
// - Monitor-mode latch write targets protect byte.
// - Programming confined to latched 32-byte row.
// - Program select latches address; byte timing.
// - Program teardown waits are software's duty.
// - Software never exceeds maximum program time.
// - Software erases a row before programming.
// - Sequences run from outside the array.
// - High voltage refused inside protected range.
// - Software reads protect byte before high voltage.
// - Protect start is 11, bits, six zeros.
// - All zeros protect all; all ones none.
// - Locked protect byte cannot be altered.
// - Test high voltage bypasses block protection.
// - Erased reads one; page is two rows.
`timescale 1ns/1ps
module fpe_flash_ctrl
  import fpe_pkg::*;
#(
  parameter int         ARRAY_BYTES = 16384,
  parameter logic [7:0] PROT_INIT   = 8'hff
)(
  input  wire logic CLK_SYS,
  input  wire logic ARST_N,
  input  wire logic CE,
  input  wire logic TEST_HV,
  input  wire logic STANDBY,
  output logic      HV_ON,
  output logic      REFUSED,
  fpe_if.dev        bus
);

  if (ARRAY_BYTES != 16384)
    $error("fpe_flash_ctrl: the address map serves a 16 Kbyte array only");

  typedef enum logic [4:0] {
    D_IDLE    = 5'h01,
    D_SEL     = 5'h02,
    D_PREAD   = 5'h04,
    D_LATCHED = 5'h08,
    D_ACTIVE  = 5'h10
  } fpe_dstate_t;

  // Protected when at or above the start address; open byte means none.
  function automatic logic prot_hit(input logic [15:0] a,
                                    input logic [7:0]  p,
                                    input logic        bypass);
    prot_hit = !bypass && (p != PROT_OPEN)
               && (a >= {2'h3, p, 6'h00});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Test voltage pin synchroniser.

  logic [2:0] tst_s_q;
  logic       tst_q;
  logic       tst_d;

  always_comb
  begin
    tst_d = tst_q;
    if (tst_s_q[1] == tst_s_q[2])
      tst_d = tst_s_q[2];
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tst_s_q <= 3'h0;
      tst_q   <= 1'b0;
    end
    else if (CE)
    begin
      tst_s_q <= {tst_s_q[1:0], TEST_HV};
      tst_q   <= tst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control byte, sequence state and protect byte.

  fpe_dstate_t st_q, st_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [7:0]  prot_q, prot_d;
  logic [15:0] latch_q, latch_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        ref_q, ref_d;
  logic        ctl_wr, arr_wr, in_arr;
  logic        prog_wr, pg_erase, ms_erase;
  logic        w_psel, w_era, w_hv;
  logic [7:0]  mem [0:ARRAY_BYTES-1];

  assign in_arr = bus.bus_addr >= ARRAY_BASE;
  assign ctl_wr = bus.bus_wr && bus.bus_ctl;
  assign arr_wr = bus.bus_wr && !bus.bus_ctl && in_arr;
  assign w_psel = bus.bus_wdata[CTL_PSEL];
  assign w_era  = bus.bus_wdata[CTL_ERASE];
  assign w_hv   = bus.bus_wdata[CTL_HVE];

  always_comb
  begin
    st_d     = st_q;
    ctl_d    = ctl_q;
    prot_d   = prot_q;
    latch_d  = latch_q;
    rdata_d  = rdata_q;
    ref_d    = 1'b0;
    prog_wr  = 1'b0;
    pg_erase = 1'b0;
    ms_erase = 1'b0;
    if (bus.bus_rd)
    begin
      if (bus.bus_ctl)
        rdata_d = ctl_q;
      else if (bus.bus_addr == PROT_ADDR)
        rdata_d = prot_q;
      else if (in_arr)
        rdata_d = mem[bus.bus_addr[13:0]];
      else
        rdata_d = 8'h00;
    end
    if (STANDBY)
    begin
      // Wait or stop during an operation abandons it.
      ctl_d = CTL_RESET;
      st_d  = D_IDLE;
    end
    else if (ctl_wr)
    begin
      if ((w_psel && w_era) || (w_psel && ctl_q[CTL_ERASE])
          || (w_era && ctl_q[CTL_PSEL]))
        ref_d = 1'b1;
      else
      begin
        ctl_d = bus.bus_wdata;
        ctl_d[7:4] = 4'h0;
        if (w_hv && !ctl_q[CTL_HVE])
        begin
          // High voltage needs select, protect read, latch and open target.
          if (st_q != D_LATCHED || !(w_psel || w_era)
              || prot_hit(latch_q, prot_q, tst_q)
              || (bus.bus_wdata[CTL_MASS] && prot_q != PROT_OPEN
                  && !tst_q))
          begin
            ctl_d[CTL_HVE] = 1'b0;
            ref_d = 1'b1;
          end
          else
            st_d = D_ACTIVE;
        end
        if (ctl_q[CTL_HVE] && ctl_q[CTL_ERASE] && !w_era)
        begin
          if (ctl_q[CTL_MASS])
            ms_erase = 1'b1;
          else if (latch_q[15:6] == SEC_PAGE[15:6])
            ref_d = 1'b1;
          else
            pg_erase = 1'b1;
        end
        if (!w_psel && !w_era && !(w_hv && ctl_q[CTL_HVE]))
          st_d = D_IDLE;
        else if (st_q == D_IDLE && (w_psel || w_era))
          st_d = D_SEL;
      end
    end
    else if (bus.bus_rd && !bus.bus_ctl && bus.bus_addr == PROT_ADDR
             && st_q == D_SEL)
      st_d = D_PREAD;
    else if (arr_wr && st_q == D_PREAD)
    begin
      latch_d = bus.bus_addr;
      st_d    = D_LATCHED;
    end
    else if (arr_wr && st_q == D_ACTIVE && ctl_q[CTL_PSEL])
    begin
      if (bus.bus_addr[15:5] != latch_q[15:5]
          || prot_hit(bus.bus_addr, prot_q, tst_q))
        ref_d = 1'b1;
      else
      begin
        prog_wr = 1'b1;
        if (bus.bus_addr == PROT_ADDR)
          prot_d = prot_q & bus.bus_wdata;
      end
    end
    if (ms_erase)
      prot_d = ERASED;
    else if (pg_erase && latch_q[15:6] == PROT_ADDR[15:6])
      prot_d = ERASED;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_q    <= D_IDLE;
      ctl_q   <= CTL_RESET;
      prot_q  <= PROT_INIT;
      latch_q <= 16'h0000;
      rdata_q <= 8'h00;
      ref_q   <= 1'b0;
    end
    else if (CE)
    begin
      st_q    <= st_d;
      ctl_q   <= ctl_d;
      prot_q  <= prot_d;
      latch_q <= latch_d;
      rdata_q <= rdata_d;
      ref_q   <= ref_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array. Flash cells keep no reset; the whole erase in one cycle trades
  // area for a model that needs no erase timer of its own.

  always_ff @(posedge CLK_SYS)
  begin
    if (CE)
    begin
      if (ms_erase)
      begin
        for (int i = 0; i < ARRAY_BYTES; i++)
          mem[i] <= ERASED;
      end
      else if (pg_erase)
      begin
        for (int i = 0; i < PAGE_BYTES; i++)
          mem[{latch_q[13:6], i[5:0]}] <= ERASED;
      end
      else if (prog_wr)
        mem[bus.bus_addr[13:0]] <= mem[bus.bus_addr[13:0]]
                                   & bus.bus_wdata;
    end
  end

  assign bus.bus_rdata = rdata_q;
  assign HV_ON         = ctl_q[CTL_HVE];
  assign REFUSED       = ref_q;

endmodule

// [rtl/fpe_cpu_seq.sv]
// CPU-side sequencer that runs program and erase procedures with their
// minimum waits. Assumes fpe_flash_ctrl on the other end of fpe_if.cpu.
`timescale 1ns/1ps
module fpe_cpu_seq
  import fpe_pkg::*;
#(
  parameter int ERASE_CYC = T_ERASE_CYC,
  parameter int PAGE_CYC  = T_ERASE_CYC
)(
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        CMD_VALID,
  input  wire logic [1:0]  CMD_OP,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [7:0]  CMD_DATA,
  output logic             CMD_READY,
  output logic             DONE,
  fpe_if.cpu               bus
);

  localparam int CW = 19;
  if (ERASE_CYC >= 2**CW || PAGE_CYC >= 2**CW || ERASE_CYC < 1
      || PAGE_CYC < 1)
    $error("fpe_cpu_seq: erase counts must fit the wait counter");

  typedef enum logic [11:0] {
    H_IDLE  = 12'h001,
    H_SEL   = 12'h002,
    H_RDP   = 12'h004,
    H_LATCH = 12'h008,
    H_SETUP = 12'h010,
    H_HVON  = 12'h020,
    H_HOLD  = 12'h040,
    H_WRB   = 12'h080,
    H_DESEL = 12'h100,
    H_KEEP  = 12'h200,
    H_HVOFF = 12'h400,
    H_RECOV = 12'h800
  } fpe_hstate_t;

  fpe_hstate_t st_q, st_d;
  fpe_op_t     op_q, op_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0]  data_q, data_d, sel_q, sel_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic        wr_q, wr_d, rd_q, rd_d, ctl_q, ctl_d, done_q, done_d;
  logic [15:0] baddr_q, baddr_d;
  logic [7:0]  bdata_q, bdata_d;

  always_comb
  begin
    st_d    = st_q;
    op_d    = op_q;
    addr_d  = addr_q;
    data_d  = data_q;
    sel_d   = sel_q;
    cnt_d   = cnt_q;
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    ctl_d   = 1'b0;
    done_d  = 1'b0;
    baddr_d = baddr_q;
    bdata_d = bdata_q;
    if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
    else
      case (st_q)
        H_IDLE:
          if (CMD_VALID)
          begin
            op_d   = fpe_op_t'(CMD_OP);
            addr_d = CMD_ADDR;
            data_d = CMD_DATA;
            sel_d  = 8'h00;
            if (fpe_op_t'(CMD_OP) == OP_PROGRAM)
              sel_d[CTL_PSEL] = 1'b1;
            else
              sel_d[CTL_ERASE] = 1'b1;
            if (fpe_op_t'(CMD_OP) == OP_MASS_ERASE)
              sel_d[CTL_MASS] = 1'b1;
            st_d = H_SEL;
          end
        H_SEL:
        begin
          wr_d    = 1'b1;
          ctl_d   = 1'b1;
          bdata_d = sel_q;
          st_d    = H_RDP;
        end
        H_RDP:
        begin
          rd_d    = 1'b1;
          baddr_d = PROT_ADDR;
          st_d    = H_LATCH;
        end
        H_LATCH:
        begin
          // Monitor-mode mass erase may aim this write at the protect byte.
          wr_d    = 1'b1;
          baddr_d = addr_q;
          bdata_d = data_q;
          st_d    = H_SETUP;
          cnt_d   = CW'(T_HVSU_CYC - 1);
        end
        H_SETUP:
        begin
          wr_d    = 1'b1;
          ctl_d   = 1'b1;
          bdata_d = sel_q | (8'h01 << CTL_HVE);
          st_d    = H_HVON;
        end
        H_HVON:
        begin
          st_d = (op_q == OP_PROGRAM) ? H_WRB : H_HOLD;
          if (op_q == OP_PROGRAM)
            cnt_d = CW'(T_PSU_CYC - 1);
          else if (op_q == OP_MASS_ERASE)
            cnt_d = CW'(ERASE_CYC - 1);
          else
            cnt_d = CW'(PAGE_CYC - 1);
        end
        H_WRB:
        begin
          wr_d    = 1'b1;
          baddr_d = addr_q;
          bdata_d = data_q;
          st_d    = H_HOLD;
          cnt_d   = CW'(T_BYTE_CYC - 1);
        end
        H_HOLD:
          st_d = H_DESEL;
        H_DESEL:
        begin
          wr_d    = 1'b1;
          ctl_d   = 1'b1;
          bdata_d = 8'h01 << CTL_HVE;
          st_d    = H_KEEP;
          cnt_d   = (op_q == OP_MASS_ERASE) ? CW'(T_MEHD_CYC - 1)
                                            : CW'(T_HVHD_CYC - 1);
        end
        H_KEEP:
        begin
          wr_d    = 1'b1;
          ctl_d   = 1'b1;
          bdata_d = 8'h00;
          st_d    = H_HVOFF;
        end
        H_HVOFF:
        begin
          st_d  = H_RECOV;
          cnt_d = CW'(T_RREC_CYC - 1);
        end
        H_RECOV:
        begin
          done_d = 1'b1;
          st_d   = H_IDLE;
        end
        default:
          st_d = H_IDLE;
      endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_q    <= H_IDLE;
      op_q    <= OP_PROGRAM;
      addr_q  <= 16'h0000;
      data_q  <= 8'h00;
      sel_q   <= 8'h00;
      cnt_q   <= '0;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      ctl_q   <= 1'b0;
      done_q  <= 1'b0;
      baddr_q <= 16'h0000;
      bdata_q <= 8'h00;
    end
    else if (CE)
    begin
      st_q    <= st_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
      sel_q   <= sel_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      ctl_q   <= ctl_d;
      done_q  <= done_d;
      baddr_q <= baddr_d;
      bdata_q <= bdata_d;
    end
  end

  // Strobes are gated so a frozen clock enable never repeats an access.
  assign bus.bus_wr    = wr_q && CE;
  assign bus.bus_rd    = rd_q && CE;
  assign bus.bus_ctl   = ctl_q;
  assign bus.bus_addr  = baddr_q;
  assign bus.bus_wdata = bdata_q;
  assign CMD_READY     = (st_q == H_IDLE) && (cnt_q == '0);
  assign DONE          = done_q;

endmodule

// [verification/fpe_link_props.sv]
// Checker for the byte bus joining the sequencer and the flash control.
// Assumes the testbench places it beside the interface of the main link.
`timescale 1ns/1ps
module fpe_link_props
  import fpe_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic        bus_ctl,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        HV_ON,
  input wire logic        REFUSED
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  wire ctl_wr = bus_wr && bus_ctl;
  wire arr_wr = bus_wr && !bus_ctl;
  wire hv_req = ctl_wr && bus_wdata[3] && (bus_wdata[0] ^ bus_wdata[1]);
  logic [15:0] gap_q;
  // Saturates so that a long erase wait never wraps into a short one.
  always_ff @(posedge CLK_SYS or negedge ARST_N)
    if (!ARST_N)
      gap_q <= 16'h0000;
    else if (bus_wr)
      gap_q <= 16'h0001;
    else if (gap_q != 16'hffff)
      gap_q <= gap_q + 16'h0001;
  //////////////////////////////////////////////////////////////////////
  sequence sel_wr_s;
    ctl_wr && bus_wdata[1:0] != 2'h0 && !bus_wdata[3] && !HV_ON;
  endsequence
  sequence prot_rd_s;
    bus_rd && !bus_ctl && bus_addr == PROT_ADDR;
  endsequence
  sequence latch_s;
    arr_wr && !HV_ON;
  endsequence
  sel_order_a:
    assert property (sel_wr_s |=> prot_rd_s ##1 latch_s)
    else $error("select not followed by protect read and latch");
  hv_set_a:
    assert property (hv_req && !HV_ON |=> HV_ON)
    else $error("high voltage not raised after legal request");
  hv_cause_a:
    assert property ($rose(HV_ON) |-> $past(hv_req))
    else $error("high voltage rose without a request");
  hv_off_a:
    assert property (ctl_wr && !bus_wdata[3] |=> !HV_ON)
    else $error("high voltage still on after clear");
  no_both_a:
    assert property (ctl_wr |-> !(bus_wdata[0] && bus_wdata[1]))
    else $error("both selects written together");
  nvs_wait_a:
    assert property (ctl_wr && bus_wdata[3] && !HV_ON |-> gap_q >= T_HVSU_CYC)
    else $error("setup wait too short");
  pgs_wait_a:
    assert property (arr_wr && HV_ON |-> gap_q >= T_PSU_CYC)
    else $error("program setup wait too short");
  nvh_wait_a:
    assert property (ctl_wr && !bus_wdata[3] && HV_ON |-> gap_q >= T_HVHD_CYC)
    else $error("hold wait too short");
  prot_val_a:
    assert property (prot_rd_s |=> bus_rdata == PROT_OPEN)
    else $error("open protect byte read wrong");
  no_refuse_a:
    assert property (!REFUSED)
    else $error("legal sequence refused");
endmodule

// [verification/tb_top.sv]
// Testbench: the sequencer drives one flash control, while the bench
// itself drives a second flash control to provoke refusals.
`timescale 1ns/1ps
module tb_top
  import fpe_pkg::*;
  ;
  logic        clk, rst_n, ce, test_hv, stby2, hv_on, hv2, ref_m, ref2;
  logic        cmd_valid, cmd_ready, done, rf, rfa;
  logic [1:0]  cmd_op;
  logic [15:0] cmd_addr;
  logic [7:0]  cmd_data, prot_exp;
  int          failures, checks_done, cyc;
  fpe_if link ();
  fpe_if b2 ();
  fpe_flash_ctrl fpe_flash_ctrl_i (.CLK_SYS(clk), .ARST_N(rst_n), .CE(ce),
    .TEST_HV(test_hv), .STANDBY(1'b0), .HV_ON(hv_on), .REFUSED(ref_m),
    .bus(link.dev));
  fpe_cpu_seq #(.ERASE_CYC(20), .PAGE_CYC(20)) fpe_cpu_seq_i (.CLK_SYS(clk),
    .ARST_N(rst_n), .CE(ce), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
    .DONE(done), .bus(link.cpu));
  fpe_flash_ctrl fpe_flash_ctrl_2_i (.CLK_SYS(clk), .ARST_N(rst_n), .CE(ce),
    .TEST_HV(test_hv), .STANDBY(stby2), .HV_ON(hv2), .REFUSED(ref2),
    .bus(b2.dev));
  fpe_link_props fpe_link_props_i (.CLK_SYS(clk), .ARST_N(rst_n),
    .bus_wr(link.bus_wr), .bus_rd(link.bus_rd), .bus_ctl(link.bus_ctl),
    .bus_addr(link.bus_addr), .bus_wdata(link.bus_wdata),
    .bus_rdata(link.bus_rdata), .HV_ON(hv_on), .REFUSED(ref_m));
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // Strobes idle one cycle between requests so no signal is set twice.
  task automatic w(input logic c, input logic [15:0] a, input logic [7:0] d);
    b2.bus_ctl = c;
    b2.bus_addr = a;
    b2.bus_wdata = d;
    b2.bus_wr = 1'b1;
    @(negedge clk);
    b2.bus_wr = 1'b0;
    rf = ref2;
    rfa = rfa | ref2;
    @(negedge clk);
  endtask
  task automatic rd(input logic c, input logic [15:0] a, input logic [7:0] e);
    b2.bus_ctl = c;
    b2.bus_addr = a;
    b2.bus_rd = 1'b1;
    @(negedge clk);
    b2.bus_rd = 1'b0;
    chk8(b2.bus_rdata, e);
    @(negedge clk);
  endtask
  task automatic arm(input logic [7:0] sel, input logic [15:0] a);
    rfa = 1'b0;
    w(1'b1, 16'h0000, sel);
    rd(1'b0, PROT_ADDR, prot_exp);
    w(1'b0, a, 8'hff);
    w(1'b1, 16'h0000, sel | 8'h08);
  endtask
  task automatic prog_byte(input logic [15:0] a, input logic [7:0] d);
    arm(8'h01, a);
    w(1'b0, a, d);
    w(1'b1, 16'h0000, 8'h08);
    w(1'b1, 16'h0000, 8'h00);
  endtask
  task automatic ers(input logic [7:0] sel, input logic [15:0] a);
    arm(sel, a);
    w(1'b1, 16'h0000, 8'h08);
    w(1'b1, 16'h0000, 8'h00);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [15:0] a);
    int n;
    logic hv;
    n = 0;
    hv = 1'b0;
    chk1(cmd_ready, 1'b1);
    cmd_op = op;
    cmd_addr = a;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 30000)
    begin
      @(negedge clk);
      hv = hv | hv_on;
      n++;
    end
    chk1(done, 1'b1);
    chk1(hv, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic s_link;
    cmd(2'h2, 16'hc000);
    cmd(2'h1, 16'hc040);
    cmd(2'h0, 16'hc000);
  endtask
  task automatic s_mass;
    ers(8'h06, 16'hc000);
    chk1(rfa, 1'b0);
    rd(1'b0, 16'hc000, ERASED);
    rd(1'b0, 16'hffff, ERASED);
  endtask
  task automatic s_prog;
    prog_byte(16'hc010, 8'h5a);
    prog_byte(16'hc010, 8'h0f);
    rd(1'b0, 16'hc010, 8'h0a);
    arm(8'h01, 16'hc000);
    w(1'b0, 16'hc020, 8'h00);
    chk1(rf, 1'b1);
    w(1'b1, 16'h0000, 8'h08);
    w(1'b1, 16'h0000, 8'h00);
    rd(1'b0, 16'hc020, ERASED);
    prog_byte(16'hffc0, 8'h00);
  endtask
  task automatic s_page;
    ers(8'h02, 16'hc000);
    rd(1'b0, 16'hc010, ERASED);
    ers(8'h02, 16'hffc0);
    chk1(rfa, 1'b1);
    rd(1'b0, 16'hffc0, 8'h00);
  endtask
  task automatic s_ctl;
    w(1'b1, 16'h0000, 8'h03);
    chk1(rf, 1'b1);
    rd(1'b1, 16'h0000, 8'h00);
    w(1'b1, 16'h0000, 8'h01);
    w(1'b1, 16'h0000, 8'h02);
    chk1(rf, 1'b1);
    rd(1'b1, 16'h0000, 8'h01);
    w(1'b1, 16'h0000, 8'h09);
    chk1(hv2, 1'b0);
    chk1(rf, 1'b1);
    stby2 = 1'b1;
    @(negedge clk);
    stby2 = 1'b0;
    rd(1'b1, 16'h0000, 8'h00);
  endtask
  task automatic s_prot;
    prog_byte(PROT_ADDR, 8'hfd);
    chk1(rfa, 1'b0);
    prot_exp = 8'hfd;
    ers(8'h06, 16'hc000);
    chk1(rfa, 1'b1);
    prog_byte(16'hff3f, 8'h00);
    chk1(rfa, 1'b0);
    rd(1'b0, 16'hff3f, 8'h00);
    prog_byte(16'hff40, 8'h00);
    chk1(rfa, 1'b1);
    prog_byte(PROT_ADDR, 8'h00);
    chk1(rfa, 1'b1);
    test_hv = 1'b1;
    repeat (5) @(negedge clk);
    prog_byte(16'hff40, 8'h00);
    chk1(rfa, 1'b0);
    rd(1'b0, 16'hff40, 8'h00);
    // Only the bypass lets the locked protect byte close the whole array.
    prog_byte(PROT_ADDR, 8'h00);
    prot_exp = 8'h00;
    test_hv = 1'b0;
    repeat (5) @(negedge clk);
    prog_byte(16'hc080, 8'h00);
    chk1(rfa, 1'b1);
    rd(1'b0, 16'hc080, ERASED);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The link needs about 18000 cycles; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      end_of_test;
    end
  end
  initial
  begin
    {clk, rst_n, test_hv, stby2, cmd_valid, rf, rfa} = '0;
    {b2.bus_wr, b2.bus_rd, b2.bus_ctl} = 3'h0;
    b2.bus_addr = 16'h0000;
    b2.bus_wdata = 8'h00;
    ce = 1'b1;
    cmd_op = 2'h0;
    cmd_addr = 16'h0000;
    cmd_data = 8'ha5;
    prot_exp = PROT_OPEN;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    s_link;
    s_mass;
    s_prog;
    s_page;
    s_ctl;
    s_prot;
    end_of_test;
  end
endmodule
